// File: verilog/pls_serdes_top.sv
// Top of the 21-bit serializer/deserializer pair: transmit path, lock timing, receive output
// Operation
// - The transmitter takes its parallel word on each rising edge of the parallel strobe after lock; edges in power-save or lock wait are dropped.
// - All 21 bits of each taken word that starts a frame are spread over the serial data outputs.
// - Each lane carries seven bit slots per forwarded clock period and the receiver takes seven.
// - Three serial data lanes leave the transmitter and three enter the receiver.
// - The forwarded clock travels on its own fourth pair beside the three data lanes.
// - The transmitter makes the forwarded clock and the receiver frames data with it.
// - Transmit power-save low puts every serial data and clock output in high impedance.
// - The receiver shows each word rebuilt after lock with a parallel strobe whose rising edge marks it.
// - Receive power-save low holds the parallel outputs at their last values.
// - After power-save release the serial outputs toggle only once the 10 ms lock time ends.
// - When the incoming forwarded clock stops, the receiver strobe stops and the word holds.
`default_nettype none
module pls_serdes_top
	import pls_pkg::*;
#(
	parameter int LOCK_CYC = pls_pkg::LOCK_CYCLES,
	parameter int BIT_DIV_P = pls_pkg::BIT_DIV
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic rx_bit_clk_i,
	input wire logic tx_power_save_n_i,
	input wire logic par_strobe_in_i,
	input wire logic [pls_pkg::WORD_W-1:0] par_word_in_i,
	output logic [pls_pkg::LANES-1:0] ser_lane_out_o,
	output logic ser_lane_oe_o,
	output logic fwd_clk_out_o,
	output logic fwd_clk_oe_o,
	input wire logic rx_power_save_n_i,
	input wire logic [pls_pkg::LANES-1:0] ser_lane_in_i,
	input wire logic fwd_clk_in_i,
	output logic [pls_pkg::WORD_W-1:0] par_word_out_o,
	output logic par_strobe_out_o
);
	import pls_pkg::*;

	localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_CYC - 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_DIV_P - 1);

	// Index 0 is the transmit side, index 1 the receive side
	logic [1:0] psn_s1_reg;
	logic [1:0] psn_s2_reg;
	logic [1:0] lk_run;
	logic [1:0] lk_on;

	always_ff @(posedge core_clk_i) begin
		psn_s1_reg <= {rx_power_save_n_i, tx_power_save_n_i};
		psn_s2_reg <= psn_s1_reg;
	end

	for (genvar g = 0; g < 2; g++) begin : g_lock
		pls_lock_t st_reg;
		pls_lock_t st_next;
		logic [CNT_W-1:0] cnt_reg;
		logic [CNT_W-1:0] cnt_next;

		always_comb begin
			st_next = st_reg;
			cnt_next = cnt_reg;
			case (st_reg)
				LK_OFF: begin
					cnt_next = '0;
					if (psn_s2_reg[g]) begin
						st_next = LK_WAIT;
					end
				end
				LK_WAIT: begin
					if (!psn_s2_reg[g]) begin
						st_next = LK_OFF;
					end else if (cnt_reg == LOCK_LAST) begin
						st_next = LK_RUN;
					end else begin
						cnt_next = cnt_reg + 32'h0000_0001;
					end
				end
				LK_RUN: begin
					if (!psn_s2_reg[g]) begin
						st_next = LK_OFF;
					end
				end
				default: begin
					st_next = LK_OFF;
				end
			endcase
		end

		always_ff @(posedge core_clk_i) begin
			if (rst_i) begin
				st_reg <= LK_OFF;
				cnt_reg <= '0;
			end else begin
				st_reg <= st_next;
				cnt_reg <= cnt_next;
			end
		end

		assign lk_run[g] = (st_reg == LK_RUN);
		assign lk_on[g] = (st_reg != LK_OFF);
	end

	// Transmit side
	logic strb_s1_reg;
	logic strb_s2_reg;
	logic strb_s3_reg;
	logic [WORD_W-1:0] pw_s1_reg;
	logic [WORD_W-1:0] pw_s2_reg;
	logic strobe_rise;

	always_ff @(posedge core_clk_i) begin
		strb_s1_reg <= par_strobe_in_i;
		strb_s2_reg <= strb_s1_reg;
		strb_s3_reg <= strb_s2_reg;
		pw_s1_reg <= par_word_in_i;
		pw_s2_reg <= pw_s1_reg;
	end

	assign strobe_rise = strb_s2_reg & ~strb_s3_reg;

	logic [WORD_W-1:0] pend_reg;
	logic [WORD_W-1:0] pend_next;
	logic pend_v_reg;
	logic pend_v_next;
	logic [WORD_W-1:0] frame_reg;
	logic [WORD_W-1:0] frame_next;
	logic busy_reg;
	logic busy_next;
	logic [DIV_W-1:0] div_reg;
	logic [DIV_W-1:0] div_next;
	logic [SLOT_W-1:0] slot_reg;
	logic [SLOT_W-1:0] slot_next;
	logic [LANES-1:0] lane_reg;
	logic [LANES-1:0] lane_next;
	logic fwd_reg;
	logic fwd_next;
	logic oe_reg;
	logic oe_next;

	always_comb begin
		pend_next = pend_reg;
		pend_v_next = pend_v_reg;
		frame_next = frame_reg;
		busy_next = busy_reg;
		div_next = div_reg;
		slot_next = slot_reg;
		if (!lk_run[0]) begin
			pend_v_next = 1'h0;
			busy_next = 1'h0;
			div_next = '0;
			slot_next = '0;
		end else begin
			if (busy_reg) begin
				if (div_reg == DIV_LAST) begin
					div_next = '0;
					if (slot_reg == SLOT_LAST) begin
						busy_next = 1'h0;
						slot_next = '0;
					end else begin
						slot_next = slot_reg + 3'h1;
					end
				end else begin
					div_next = div_reg + 8'h01;
				end
			end
			if (pend_v_reg && !busy_next) begin
				frame_next = pend_reg;
				busy_next = 1'h1;
				slot_next = '0;
				div_next = '0;
				pend_v_next = 1'h0;
			end
			// A newer strobe replaces a word still waiting for its frame
			if (strobe_rise) begin
				pend_next = pw_s2_reg;
				pend_v_next = 1'h1;
			end
		end
		for (int l = 0; l < LANES; l++) begin
			lane_next[l] = busy_next & frame_next[l * SLOTS + int'(slot_next)];
		end
		fwd_next = busy_next && (slot_next < FWD_HI_SLOTS);
		oe_next = lk_on[0];
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			pend_reg <= '0;
			pend_v_reg <= 1'h0;
			frame_reg <= '0;
			busy_reg <= 1'h0;
			div_reg <= '0;
			slot_reg <= '0;
			lane_reg <= '0;
			fwd_reg <= 1'h0;
			oe_reg <= 1'h0;
		end else begin
			pend_reg <= pend_next;
			pend_v_reg <= pend_v_next;
			frame_reg <= frame_next;
			busy_reg <= busy_next;
			div_reg <= div_next;
			slot_reg <= slot_next;
			lane_reg <= lane_next;
			fwd_reg <= fwd_next;
			oe_reg <= oe_next;
		end
	end

	assign ser_lane_out_o = lane_reg;
	assign ser_lane_oe_o = oe_reg;
	assign fwd_clk_out_o = fwd_reg;
	assign fwd_clk_oe_o = oe_reg;

	// Receive side
	pls_rx_if rx_lnk ();

	pls_rx_front u_rx_front (
		.rx_bit_clk_i(rx_bit_clk_i),
		.rst_i(rst_i),
		.ser_lane_in_i(ser_lane_in_i),
		.fwd_clk_in_i(fwd_clk_in_i),
		.lnk(rx_lnk.link)
	);

	logic tg_s1_reg;
	logic tg_s2_reg;
	logic tg_s3_reg;
	logic new_word;
	logic [WORD_W-1:0] rword_reg;
	logic [WORD_W-1:0] rword_next;
	logic rstb_reg;
	logic rstb_next;
	logic ld_d_reg;
	logic ld_d_next;

	always_ff @(posedge core_clk_i) begin
		tg_s1_reg <= rx_lnk.toggle;
		tg_s2_reg <= tg_s1_reg;
		tg_s3_reg <= tg_s2_reg;
	end

	// Word is stable for a whole frame after its toggle, far longer than the sync delay
	assign new_word = tg_s2_reg ^ tg_s3_reg;

	always_comb begin
		rword_next = rword_reg;
		rstb_next = rstb_reg;
		ld_d_next = 1'h0;
		if (lk_run[1]) begin
			if (new_word) begin
				rword_next = rx_lnk.word;
				rstb_next = 1'h0;
				ld_d_next = 1'h1;
			end else if (ld_d_reg) begin
				rstb_next = 1'h1;
			end
		end
		// Otherwise word and strobe hold: power-save, lock wait or no frames arriving
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rword_reg <= '0;
			rstb_reg <= 1'h0;
			ld_d_reg <= 1'h0;
		end else begin
			rword_reg <= rword_next;
			rstb_reg <= rstb_next;
			ld_d_reg <= ld_d_next;
		end
	end

	assign par_word_out_o = rword_reg;
	assign par_strobe_out_o = rstb_reg;
endmodule
`default_nettype wire

// File: include/pls_pkg.sv
// Shared constants and types for the 21-bit parallel serializer/deserializer pair
`default_nettype none
package pls_pkg;
	localparam int WORD_W = 21;
	localparam int LANES = 3;
	localparam int SLOTS = 7;
	localparam int SLOT_W = 3;
	localparam logic [SLOT_W-1:0] SLOT_LAST = 3'h6;
	localparam logic [SLOT_W-1:0] SLOT_IDLE = 3'h7;
	// Forwarded clock is high during slots 0..3, low during 4..6
	localparam logic [SLOT_W-1:0] FWD_HI_SLOTS = 3'h4;
	localparam int CORE_CLK_MHZ = 200;
	localparam int LOCK_TIME_MS = 10;
	localparam int LOCK_CYCLES = LOCK_TIME_MS * 1000 * CORE_CLK_MHZ;
	// Core cycles per serial bit slot on the transmit side
	localparam int BIT_DIV = 4;
	localparam int DIV_W = 8;
	localparam int CNT_W = 32;
	typedef enum logic [2:0] {
		LK_OFF = 3'b001,
		LK_WAIT = 3'b010,
		LK_RUN = 3'b100
	} pls_lock_t;
endpackage
`default_nettype wire

// File: include/pls_rx_if.sv
// Word hand-off from the link-clock receive front end to the core domain
`default_nettype none
interface pls_rx_if;
	logic [pls_pkg::WORD_W-1:0] word;
	logic toggle;
	modport link (output word, output toggle);
	modport core (input word, input toggle);
endinterface
`default_nettype wire

// File: verilog/pls_rx_front.sv
// Receive front end: samples the serial lanes on the link bit clock and rebuilds words
`default_nettype none
module pls_rx_front
	import pls_pkg::*;
(
	input wire logic rx_bit_clk_i,
	input wire logic rst_i,
	input wire logic [pls_pkg::LANES-1:0] ser_lane_in_i,
	input wire logic fwd_clk_in_i,
	pls_rx_if.link lnk
);
	import pls_pkg::*;
	logic rs1_reg;
	logic rs2_reg;
	logic [LANES-1:0] ln_s1_reg;
	logic [LANES-1:0] ln_s2_reg;
	logic ck_s1_reg;
	logic ck_s2_reg;
	logic ck_s3_reg;
	logic [LANES-1:0][SLOTS-1:0] sh_reg;
	logic [LANES-1:0][SLOTS-1:0] sh_next;
	logic [SLOT_W-1:0] cnt_reg;
	logic [SLOT_W-1:0] cnt_next;
	logic [WORD_W-1:0] word_reg;
	logic [WORD_W-1:0] word_next;
	logic tog_reg;
	logic tog_next;
	logic rise;

	// Core reset carried into this domain; needs the bit clock running to apply
	always_ff @(posedge rx_bit_clk_i) begin
		rs1_reg <= rst_i;
		rs2_reg <= rs1_reg;
	end

	// Lanes and clock pair share equal synchroniser depth so alignment is kept
	always_ff @(posedge rx_bit_clk_i) begin
		ln_s1_reg <= ser_lane_in_i;
		ln_s2_reg <= ln_s1_reg;
		ck_s1_reg <= fwd_clk_in_i;
		ck_s2_reg <= ck_s1_reg;
		ck_s3_reg <= ck_s2_reg;
	end

	assign rise = ck_s2_reg & ~ck_s3_reg;

	always_comb begin
		sh_next = sh_reg;
		cnt_next = cnt_reg;
		word_next = word_reg;
		tog_next = tog_reg;
		if (rise || cnt_reg != SLOT_IDLE) begin
			for (int l = 0; l < LANES; l++) begin
				sh_next[l] = {ln_s2_reg[l], sh_reg[l][SLOTS-1:1]};
			end
		end
		if (rise) begin
			// Forwarded clock rise marks slot 0 of every lane
			cnt_next = 3'h1;
		end else if (cnt_reg != SLOT_IDLE) begin
			cnt_next = cnt_reg + 3'h1;
			if (cnt_reg == SLOT_LAST) begin
				// Bit l*7+s comes from lane l, slot s
				word_next = sh_next;
				tog_next = ~tog_reg;
			end
		end
	end

	// A stopped forwarded clock leaves the last word and toggle untouched
	always_ff @(posedge rx_bit_clk_i) begin
		if (rs2_reg) begin
			sh_reg <= '0;
			cnt_reg <= SLOT_IDLE;
			word_reg <= '0;
			tog_reg <= 1'h0;
		end else begin
			sh_reg <= sh_next;
			cnt_reg <= cnt_next;
			word_reg <= word_next;
			tog_reg <= tog_next;
		end
	end

	assign lnk.word = word_reg;
	assign lnk.toggle = tog_reg;
endmodule
`default_nettype wire

// File: sim/pls_serdes_props.sv
// Port-level checks on the serializer/deserializer top
`default_nettype none
module pls_serdes_props
	import pls_pkg::*;
#(
	parameter int LOCK_CYC = 20,
	parameter int BIT_DIV_P = 4
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic tx_power_save_n_i,
	input wire logic rx_power_save_n_i,
	input wire logic [pls_pkg::LANES-1:0] ser_lane_out_o,
	input wire logic ser_lane_oe_o,
	input wire logic fwd_clk_out_o,
	input wire logic fwd_clk_oe_o,
	input wire logic [pls_pkg::WORD_W-1:0] par_word_out_o,
	input wire logic par_strobe_out_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] tx_up_reg, tx_up_next, rx_up_reg, rx_up_next;
	always_comb begin
		tx_up_next = tx_up_reg < LOCK_CYC ? tx_up_reg + 32'h0000_0001 : tx_up_reg;
		rx_up_next = rx_up_reg < LOCK_CYC ? rx_up_reg + 32'h0000_0001 : rx_up_reg;
		if (!tx_power_save_n_i)
			tx_up_next = '0;
		if (!rx_power_save_n_i)
			rx_up_next = '0;
	end
	always_ff @(posedge core_clk_i) begin
		tx_up_reg <= rst_i ? '0 : tx_up_next;
		rx_up_reg <= rst_i ? '0 : rx_up_next;
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// Slot lengths below assume BIT_DIV_P of 4
	chk_fwd_high_run: assert property ($rose(fwd_clk_out_o) |-> fwd_clk_out_o[*8] ##1
		fwd_clk_out_o[*8] ##1 !fwd_clk_out_o) else $error("forwarded clock high time wrong");
	chk_fwd_low_run: assert property ($fell(fwd_clk_out_o) |-> (!fwd_clk_out_o)[*8] ##1
		(!fwd_clk_out_o)[*4]) else $error("forwarded clock low time wrong");
	chk_slot_hold: assert property ($rose(fwd_clk_out_o) |=> $stable(ser_lane_out_o)[*3])
		else $error("lane changed inside a slot");
	chk_oe_shared: assert property (ser_lane_oe_o == fwd_clk_oe_o)
		else $error("clock and lane enables differ");
	chk_hiz_quiet: assert property (!ser_lane_oe_o |-> ser_lane_out_o == '0 && !fwd_clk_out_o)
		else $error("outputs move while undriven");
	chk_ps_tristate: assert property ((!tx_power_save_n_i)[*6] |-> !ser_lane_oe_o)
		else $error("outputs still driven in power save");
	chk_tx_lock_quiet: assert property (tx_power_save_n_i && tx_up_reg < LOCK_CYC
		|-> !fwd_clk_out_o) else $error("clock toggles before lock");
	chk_rx_lock_hold: assert property (rx_power_save_n_i && rx_up_reg < LOCK_CYC
		|-> $stable(par_word_out_o)) else $error("word changed before lock");
	chk_rx_ps_freeze: assert property ((!rx_power_save_n_i)[*6] |-> $stable(par_word_out_o)
		&& $stable(par_strobe_out_o)) else $error("receive outputs move in power save");
	chk_strobe_low_one: assert property ($fell(par_strobe_out_o) |=> par_strobe_out_o)
		else $error("receive strobe low too long");
	chk_word_at_low: assert property ($changed(par_word_out_o) |-> !par_strobe_out_o)
		else $error("word changed while strobe high");
endmodule
`default_nettype wire

// File: sim/pls_link_model.sv
// Far-end serializer model feeding the receive lanes
`default_nettype none
module pls_link_model
	import pls_pkg::*;
(
	input wire logic rx_bit_clk_i,
	output logic [pls_pkg::LANES-1:0] ser_lane_in_o,
	output logic fwd_clk_in_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ser_lane_in_o = 3'h0;
		fwd_clk_in_o = 1'b0;
	end
	// Change on the falling edge, half a bit before sampling
	task automatic send(input logic [WORD_W-1:0] w);
		for (int s = 0; s < SLOTS; s++) begin
			@(negedge rx_bit_clk_i);
			ser_lane_in_o = {w[14+s], w[7+s], w[s]};
			fwd_clk_in_o = s < 4;
		end
		@(negedge rx_bit_clk_i);
		// Released lanes invert so a stale copy never passes
		ser_lane_in_o = ~ser_lane_in_o;
		fwd_clk_in_o = 1'b0;
	endtask
endmodule
`default_nettype wire

// File: sim/pls_serdes_top_tb.sv
// Self-checking bench for the serializer/deserializer top
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module pls_serdes_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pls_pkg::*;
	localparam int LK = 20;
	logic core_clk_i = 1'b0, rx_bit_clk_i = 1'b0, rst_i = 1'b1;
	logic tx_power_save_n_i = 1'b1, rx_power_save_n_i = 1'b1, par_strobe_in_i = 1'b0;
	logic [WORD_W-1:0] par_word_in_i = '0, par_word_out_o;
	logic [LANES-1:0] ser_lane_out_o, ser_lane_in_i;
	logic ser_lane_oe_o, fwd_clk_out_o, fwd_clk_oe_o, fwd_clk_in_i, par_strobe_out_o;
	int miscompares = 0, check_count = 0, cycles = 0;
	pls_serdes_top #(.LOCK_CYC(LK), .BIT_DIV_P(BIT_DIV)) dut (.core_clk_i, .rst_i,
		.rx_bit_clk_i, .tx_power_save_n_i, .par_strobe_in_i, .par_word_in_i, .ser_lane_out_o,
		.ser_lane_oe_o, .fwd_clk_out_o, .fwd_clk_oe_o, .rx_power_save_n_i, .ser_lane_in_i,
		.fwd_clk_in_i, .par_word_out_o, .par_strobe_out_o);
	pls_link_model lnk (.rx_bit_clk_i, .ser_lane_in_o(ser_lane_in_i), .fwd_clk_in_o(fwd_clk_in_i));
	initial forever #2.5 core_clk_i = ~core_clk_i;
	initial begin
		#37;
		forever #80 rx_bit_clk_i = ~rx_bit_clk_i;
	end
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 6000) begin
			miscompares++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tx_word(input logic [WORD_W-1:0] w);
		int n;
		n = 0;
		par_word_in_i = w;
		@(negedge core_clk_i);
		par_strobe_in_i = 1'b1;
		while (fwd_clk_out_o !== 1'b1 && n < 20) begin
			@(negedge core_clk_i);
			n++;
		end
		for (int s = 0; s < SLOTS; s++) begin
			repeat (2) @(negedge core_clk_i);
			`CHK("tx lanes", {w[14+s], w[7+s], w[s]}, ser_lane_out_o)
			`CHK("tx fwd clk", s < 4, fwd_clk_out_o)
			repeat (2) @(negedge core_clk_i);
		end
		`CHK("tx end", 4'h0, {fwd_clk_out_o, ser_lane_out_o})
		par_strobe_in_i = 1'b0;
	endtask
	task automatic got_word(input logic [WORD_W-1:0] w);
		int n;
		logic prev;
		logic [WORD_W-1:0] early;
		n = 0;
		// Strobe sits low from reset until the first word, so wait for a real rise
		prev = 1'b1;
		early = '0;
		while (!(prev === 1'b0 && par_strobe_out_o === 1'b1) && n < 600) begin
			prev = par_strobe_out_o;
			early = par_word_out_o;
			@(negedge core_clk_i);
			n++;
		end
		`CHK("rx strobe", 1'b1, par_strobe_out_o)
		`CHK("rx setup", w, early)
		`CHK("rx word", w, par_word_out_o)
	endtask
	task automatic rx_words(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b);
		fork
			begin
				lnk.send(a);
				lnk.send(b);
			end
			begin
				got_word(a);
				got_word(b);
			end
		join
	endtask
	task automatic ps_tx();
		int rises;
		rises = 0;
		tx_power_save_n_i = 1'b0;
		repeat (8) @(negedge core_clk_i);
		`CHK("tx oe off", 2'b00, {ser_lane_oe_o, fwd_clk_oe_o})
		par_strobe_in_i = 1'b1;
		repeat (4) @(negedge core_clk_i);
		par_strobe_in_i = 1'b0;
		tx_power_save_n_i = 1'b1;
		repeat (3) @(negedge core_clk_i);
		// Strobe inside the lock wait must be dropped, not queued
		par_strobe_in_i = 1'b1;
		repeat (LK) begin
			@(negedge core_clk_i);
			rises += int'(fwd_clk_out_o === 1'b1);
		end
		`CHK("tx lock", 0, rises)
		`CHK("tx oe on", 2'b11, {ser_lane_oe_o, fwd_clk_oe_o})
		par_strobe_in_i = 1'b0;
		repeat (5) @(negedge core_clk_i);
		`CHK("tx idle", 1'b0, fwd_clk_out_o)
		tx_word(21'h1_f00f);
	endtask
	task automatic ps_rx();
		logic [WORD_W-1:0] held;
		// Last word delivered before power-save
		held = 21'h0_a5a5;
		rx_power_save_n_i = 1'b0;
		repeat (8) @(negedge core_clk_i);
		`CHK("rx before ps", held, par_word_out_o)
		lnk.send(21'h0_0f0f);
		repeat (400) @(negedge core_clk_i);
		`CHK("rx held", held, par_word_out_o)
		// Word reaches the core about 145 cycles after the slot-4 fall: inside the lock wait
		fork
			lnk.send(21'h1_7e7e);
			begin
				@(negedge fwd_clk_in_i);
				repeat (136) @(negedge core_clk_i);
				rx_power_save_n_i = 1'b1;
			end
		join
		repeat (400) @(negedge core_clk_i);
		`CHK("rx stopped", held, par_word_out_o)
		rx_words(21'h1_3c3c, 21'h0_c3c3);
	endtask
	initial begin
		// Long reset so the link-clock side sees it too
		repeat (100) @(negedge core_clk_i);
		rst_i = 1'b0;
		repeat (LK + 10) @(negedge core_clk_i);
		tx_word(21'h1_2345);
		tx_word(21'h0_a5c3);
		rx_words(21'h1_5a5a, 21'h0_a5a5);
		ps_tx();
		ps_rx();
		conclude();
	end
endmodule
bind pls_serdes_top pls_serdes_props #(.LOCK_CYC(LOCK_CYC), .BIT_DIV_P(BIT_DIV_P)) u_props (
	.core_clk_i, .rst_i, .tx_power_save_n_i, .rx_power_save_n_i, .ser_lane_out_o,
	.ser_lane_oe_o, .fwd_clk_out_o, .fwd_clk_oe_o, .par_word_out_o, .par_strobe_out_o);
`default_nettype wire
